// File: logic/mau_pkg.sv
/*
 * Constants and carriers shared by the memory access unit.
 * Assumes a 64-bit element; 32-bit mode uses the low word only, except fill response data, returned whole.
 */
package mau_pkg;

	localparam int          MAU_AW         = 64;
	localparam int          MAU_DW         = 64;
	localparam int          MAU_NB         = 8;
	localparam logic [7:0]  MAU_BE_RST     = 8'h00;
	localparam logic [2:0]  MAU_ATTR_UNC   = 3'h2;
	localparam logic [2:0]  MAU_SZ_BYTE    = 3'h0;
	localparam logic [2:0]  MAU_SZ_WORD    = 3'h3;
	localparam logic [2:0]  MAU_SZ_DWORD   = 3'h7;
	localparam logic [63:0] MAU_FILL_MASK  = 64'hFFFF_FFFF_FFFF_FFC0;

	typedef enum logic [3:0] {
		MAU_OP_LOAD  = 4'h1,
		MAU_OP_STORE = 4'h2,
		MAU_OP_PREF  = 4'h4,
		MAU_OP_SYNC  = 4'h8
	} mau_op_e;

	typedef struct packed {
		mau_op_e     op;
		logic [63:0] virt_location;
		logic        fetch_or_data_sel;
		logic        read_or_write_sel;
		logic [2:0]  size_code;
		logic [63:0] wdata;
	} mau_req_s;

	typedef struct packed {
		logic [63:0] phys_addr;
		logic [2:0]  cache_coherency_attr;
		logic        fault;
	} mau_xlat_s;

	typedef struct packed {
		logic [63:0] addr;
		logic [2:0]  cache_coherency_attr;
		logic        fetch_or_data_sel;
		logic        write;
		logic        fill;
		logic [7:0]  lane_en;
		logic [63:0] wdata;
	} mau_mem_s;

endpackage : mau_pkg

// File: logic/mau_core.sv
/*
 * Load/store access path: translate, issue one memory access, return data.
 * Assumes a translator answering in the same cycle and a memory side
 * with valid/ready request and a one-shot response.
 */
`timescale 1ns/1ps
module mau_core
	import mau_pkg::*;
(
	input  wire logic      i_clk_sys,
	input  wire logic      i_srst,
	input  wire logic      i_mode64,
	input  wire logic      i_big_endian,
	input  wire logic      i_req_valid,
	output logic           o_req_ready,
	input  wire mau_req_s  i_req,
	output logic [63:0]    o_xlat_virt,
	output logic           o_xlat_fetch,
	output logic           o_xlat_write,
	input  wire mau_xlat_s i_xlat,
	output logic           o_mem_valid,
	input  wire logic      i_mem_ready,
	output mau_mem_s       o_mem,
	input  wire logic      i_mem_rvalid,
	input  wire logic [63:0] i_mem_rdata,
	input  wire logic      i_mem_idle,
	output logic           o_rsp_valid,
	output logic [63:0]    o_rsp_data,
	output logic [7:0]     o_rsp_valid_lanes,
	output logic           o_rsp_fault
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		MAU_ST_IDLE = 5'h01,
		MAU_ST_ISSUE = 5'h02,
		MAU_ST_WAIT = 5'h04,
		MAU_ST_SYNC = 5'h08,
		MAU_ST_DONE = 5'h10
	} mau_st_e;

	mau_st_e     st_reg, st_next;
	mau_mem_s    mem_reg, mem_next;
	mau_op_e     op_reg, op_next;
	logic [2:0]  off_reg, off_next;
	logic [63:0] data_reg, data_next;
	logic [7:0]  vl_reg, vl_next;
	logic        flt_reg, flt_next;
	logic [7:0]  req_lanes_reg, req_lanes_next;

	// ------------------------------------------------------------
	// lane selection
	// ------------------------------------------------------------
	logic [2:0] lo_addr;
	logic [3:0] nbytes;
	logic [7:0] span;
	logic [7:0] lanes;
	logic [2:0] mirror;

	always_comb begin
		lo_addr = i_mode64 ? i_xlat.phys_addr[2:0]
			: {1'b0, i_xlat.phys_addr[1:0]};
		nbytes = {1'b0, i_req.size_code} + 4'h1;
		span = 8'((16'h00FF << nbytes) >> 8);
		// lowest address is the item address in either order
		mirror = i_mode64 ? 3'h7 : 3'h3;
		if (i_big_endian) begin
			lanes = 8'(span << (mirror - lo_addr - i_req.size_code));
		end else begin
			lanes = 8'(span << lo_addr);
		end
		if (!i_mode64) begin
			lanes = lanes & 8'h0F;
		end
	end

	assign o_xlat_virt  = i_req.virt_location;
	assign o_xlat_fetch = i_req.fetch_or_data_sel;
	assign o_xlat_write = i_req.read_or_write_sel;
	assign o_req_ready  = (st_reg == MAU_ST_IDLE);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		mem_next = mem_reg;
		op_next = op_reg;
		off_next = off_reg;
		data_next = data_reg;
		vl_next = vl_reg;
		flt_next = flt_reg;
		unique case (st_reg)
			MAU_ST_IDLE: begin
				if (i_req_valid) begin
					op_next = i_req.op;
					off_next = lo_addr;
					flt_next = i_xlat.fault;
					vl_next = MAU_BE_RST;
					data_next = '0;
					mem_next.addr = i_xlat.phys_addr;
					mem_next.cache_coherency_attr =
						i_xlat.cache_coherency_attr;
					mem_next.fetch_or_data_sel = i_req.fetch_or_data_sel;
					mem_next.write = (i_req.op == MAU_OP_STORE);
					mem_next.fill = 1'b0;
					mem_next.lane_en = lanes;
					// unselected store lanes carry no data
					for (int i = 0; i < MAU_NB; i++) begin
						mem_next.wdata[i*8 +: 8] = lanes[i]
							? i_req.wdata[i*8 +: 8] : 8'h00;
					end
					if (i_req.op == MAU_OP_PREF
						|| i_req.op == MAU_OP_LOAD) begin
						if (i_xlat.cache_coherency_attr != MAU_ATTR_UNC)
						begin
							// cached: whole aligned block
							mem_next.addr = i_xlat.phys_addr
								& MAU_FILL_MASK;
							mem_next.fill = 1'b1;
							mem_next.lane_en = i_mode64 ? 8'hFF : 8'h0F;
						end
					end
					if (i_xlat.fault) begin
						st_next = MAU_ST_DONE;
					end else if (i_req.op == MAU_OP_SYNC) begin
						st_next = MAU_ST_SYNC;
					end else begin
						st_next = MAU_ST_ISSUE;
					end
				end
			end
			MAU_ST_ISSUE: begin
				if (i_mem_ready) begin
					st_next = (op_reg == MAU_OP_LOAD) ? MAU_ST_WAIT
						: MAU_ST_DONE;
				end
			end
			MAU_ST_WAIT: begin
				if (i_mem_rvalid) begin
					// element-wide return, only referenced lanes valid
					data_next = mem_reg.fill ? i_mem_rdata
						: (i_mem_rdata & lane_mask(mem_reg.lane_en));
					// fill lanes cover the element, only request lanes count
					vl_next = mem_reg.fill ? req_lanes_reg
						: mem_reg.lane_en;
					st_next = MAU_ST_DONE;
				end
			end
			MAU_ST_SYNC: begin
				if (i_mem_idle) begin
					st_next = MAU_ST_DONE;
				end
			end
			MAU_ST_DONE: begin
				st_next = MAU_ST_IDLE;
			end
			default: begin
				st_next = MAU_ST_IDLE;
			end
		endcase
	end

	function automatic logic [63:0] lane_mask(input logic [7:0] le);
		for (int i = 0; i < MAU_NB; i++) begin
			lane_mask[i*8 +: 8] = {8{le[i]}};
		end
	endfunction : lane_mask

	always_comb begin
		req_lanes_next = req_lanes_reg;
		if (st_reg == MAU_ST_IDLE && i_req_valid) begin
			req_lanes_next = lanes;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			st_reg <= MAU_ST_IDLE;
			mem_reg <= '0;
			op_reg <= MAU_OP_LOAD;
			off_reg <= 3'h0;
			data_reg <= '0;
			vl_reg <= MAU_BE_RST;
			flt_reg <= 1'b0;
			req_lanes_reg <= MAU_BE_RST;
		end else begin
			st_reg <= st_next;
			mem_reg <= mem_next;
			op_reg <= op_next;
			off_reg <= off_next;
			data_reg <= data_next;
			vl_reg <= vl_next;
			flt_reg <= flt_next;
			req_lanes_reg <= req_lanes_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_mem_valid = (st_reg == MAU_ST_ISSUE);
	assign o_mem = mem_reg;
	assign o_rsp_valid = (st_reg == MAU_ST_DONE);
	assign o_rsp_data = data_reg;
	assign o_rsp_valid_lanes = vl_reg;
	assign o_rsp_fault = flt_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	a_byte_one_lane: assert property (
		(st_reg == MAU_ST_IDLE && i_req_valid && !i_xlat.fault
		&& i_req.op == MAU_OP_STORE && i_req.size_code == MAU_SZ_BYTE)
		|=> $countones(mem_reg.lane_en) == 1)
		else $error("byte store not one lane");
	a_store_lanes_only: assert property (
		o_mem_valid && o_mem.write |->
		(o_mem.wdata & ~lane_mask(o_mem.lane_en)) == 64'h0)
		else $error("store data outside lanes");
	a_unc_no_fill: assert property (
		o_mem_valid && o_mem.cache_coherency_attr == MAU_ATTR_UNC
		|-> !o_mem.fill)
		else $error("uncached access filled");
	a_fill_whole: assert property (
		o_mem_valid && o_mem.fill |-> o_mem.lane_en[3:0] == 4'hF)
		else $error("fill smaller than element");
	a_pref_no_data: assert property (
		o_rsp_valid && op_reg == MAU_OP_PREF |-> o_rsp_valid_lanes == 8'h00)
		else $error("prefetch returned data");
	a_sync_waits: assert property (
		st_reg == MAU_ST_SYNC && !i_mem_idle |=> !o_rsp_valid)
		else $error("sync done while busy");
	a_load_answer: assert property (
		st_reg == MAU_ST_WAIT && i_mem_rvalid |=> o_rsp_valid
		##1 o_req_ready)
		else $error("load answer late");
	a_word_mode_lanes: assert property (
		o_rsp_valid && !i_mode64 |-> o_rsp_valid_lanes[7:4] == 4'h0)
		else $error("upper lanes in 32-bit mode");
	a_xlat_pass: assert property (
		st_reg == MAU_ST_IDLE && i_req_valid && !i_xlat.fault
		&& i_req.op == MAU_OP_STORE
		|=> o_mem.addr == $past(i_xlat.phys_addr)
		&& o_mem.cache_coherency_attr
		== $past(i_xlat.cache_coherency_attr))
		else $error("issued address not translated");
	a_le_start_lane: assert property (
		st_reg == MAU_ST_IDLE && i_req_valid && !i_big_endian
		&& i_mode64 && i_req.op == MAU_OP_STORE && !i_xlat.fault
		|=> mem_reg.lane_en[off_reg])
		else $error("lane span not at address");
	a_dword_lanes: assert property (
		st_reg == MAU_ST_IDLE && i_req_valid && i_mode64 && !i_xlat.fault
		&& i_req.op == MAU_OP_STORE && i_req.size_code == MAU_SZ_DWORD
		|=> mem_reg.lane_en == 8'hFF)
		else $error("doubleword lanes wrong");

	c_load: cover property (o_rsp_valid && op_reg == MAU_OP_LOAD);
	c_store: cover property (o_rsp_valid && op_reg == MAU_OP_STORE);
	c_sync: cover property (st_reg == MAU_ST_SYNC ##1 o_rsp_valid);
	c_word: cover property (o_mem_valid
		&& o_mem.lane_en == 8'h0F && !o_mem.fill);

endmodule : mau_core

// File: testbench/mau_mem_model.sv
/*
 * Memory side and translator model for the access unit bench.
 * Assumes the unit's ports on one clock with synchronous reset.
 */
`timescale 1ns/1ps
module mau_mem_model
	import mau_pkg::*;
#(
	parameter logic [63:0] RDAT = 64'hF0E1_D2C3_B4A5_9687
)
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	input  wire logic        i_slow,
	input  wire logic        i_busy,
	input  wire logic [63:0] i_virt,
	output mau_xlat_s        o_xlat,
	input  wire logic        i_mem_valid,
	input  wire mau_mem_s    i_mem,
	output logic             o_mem_ready,
	output logic             o_mem_rvalid,
	output logic [63:0]      o_mem_rdata,
	output logic             o_mem_idle,
	output mau_mem_s         o_last,
	output logic [7:0]       o_acc_cnt
);
	logic [2:0] wait_cnt;
	logic [2:0] rd_cnt;
	logic       pend;

	// translator: fixed offset, bit 20 uncached, bit 40 faults
	assign o_xlat = '{phys_addr: i_virt + 64'h1000,
		cache_coherency_attr: i_virt[20] ? MAU_ATTR_UNC : 3'h3,
		fault: i_virt[40]};
	assign o_mem_ready  = i_mem_valid && (!i_slow || wait_cnt == 3'h3);
	assign o_mem_idle   = !pend && !i_busy;

	always @(posedge i_clk_sys) begin
		o_mem_rvalid <= 1'b0;
		o_mem_rdata  <= ~o_mem_rdata;
		wait_cnt     <= (i_mem_valid && !o_mem_ready) ?
			wait_cnt + 3'h1 : 3'h0;
		if (i_srst) begin
			pend        <= 1'b0;
			wait_cnt    <= 3'h0;
			o_acc_cnt   <= 8'h00;
			o_mem_rdata <= 64'h0;
		end else if (o_mem_ready) begin
			o_last    <= i_mem;
			o_acc_cnt <= o_acc_cnt + 8'h01;
			pend      <= !i_mem.write;
			rd_cnt    <= i_slow ? 3'h4 : 3'h0;
		end else if (pend) begin
			if (rd_cnt == 3'h0) begin
				o_mem_rvalid <= 1'b1;
				o_mem_rdata  <= RDAT;
				pend         <= 1'b0;
			end
			rd_cnt <= rd_cnt - 3'h1;
		end
	end
endmodule : mau_mem_model

// File: testbench/testbench.sv
/*
 * Directed bench for the memory access unit.
 * Assumes mau_pkg and the memory model beside it.
 */
`timescale 1ns/1ps
module testbench
	import mau_pkg::*;
;
	localparam logic [63:0] RDAT = 64'hF0E1_D2C3_B4A5_9687;
	logic        clk, srst, m64, be, rq_v, slow, busy;
	logic        rq_rdy, mem_v, mem_rdy, rv, idle, rsp_v, flt;
	logic        xf, xw;
	logic [63:0] xv, rdat, rsp_d;
	logic [7:0]  rsp_l, acc;
	mau_req_s    rq;
	mau_xlat_s   xl;
	mau_mem_s    mem, last;
	int          errors, checked, lat;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	mau_core dut_u (.i_clk_sys(clk), .i_srst(srst), .i_mode64(m64),
		.i_big_endian(be), .i_req_valid(rq_v), .o_req_ready(rq_rdy),
		.i_req(rq), .o_xlat_virt(xv), .o_xlat_fetch(xf), .o_xlat_write(xw),
		.i_xlat(xl), .o_mem_valid(mem_v), .i_mem_ready(mem_rdy),
		.o_mem(mem), .i_mem_rvalid(rv), .i_mem_rdata(rdat),
		.i_mem_idle(idle), .o_rsp_valid(rsp_v), .o_rsp_data(rsp_d),
		.o_rsp_valid_lanes(rsp_l), .o_rsp_fault(flt));

	mau_mem_model #(.RDAT(RDAT)) mem_u (.i_clk_sys(clk), .i_srst(srst),
		.i_slow(slow), .i_busy(busy), .i_virt(xv), .o_xlat(xl),
		.i_mem_valid(mem_v), .i_mem(mem), .o_mem_ready(mem_rdy),
		.o_mem_rvalid(rv), .o_mem_rdata(rdat), .o_mem_idle(idle),
		.o_last(last), .o_acc_cnt(acc));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] lanes(input logic [63:0] a,
		input logic [2:0] sz);
		logic [7:0] l;
		logic [7:0] r;
		l = 8'((9'h001 << (4'(sz) + 4'h1)) - 9'h001);
		l = l << (m64 ? a[2:0] : {1'b0, a[1:0]});
		r = {<<{l}};
		if (be) l = m64 ? r : r >> 4;
		return l;
	endfunction : lanes

	function automatic logic [63:0] bm(input logic [7:0] l);
		for (int i = 0; i < 8; i++) bm[8*i +: 8] = {8{l[i]}};
	endfunction : bm

	task automatic run(input mau_op_e op, input logic [63:0] va,
		input logic [2:0] sz, input int rel);
		rq_v <= 1'b1;
		rq.op <= op;
		rq.virt_location <= va;
		rq.size_code <= sz;
		rq.read_or_write_sel <= (op == MAU_OP_STORE);
		@(posedge clk);
		chk(xv, va);
		chk(64'(xf), 64'(rq.fetch_or_data_sel));
		chk(64'(xw), 64'(op == MAU_OP_STORE));
		rq_v <= 1'b0;
		for (lat = 0; lat < 60; lat++) begin
			@(negedge clk);
			if (rsp_v === 1'b1) break;
			@(posedge clk);
			if (lat == rel) busy <= 1'b0;
		end
		chk(64'(rq_rdy), 64'h0);
		chk(64'(lat < 60), 64'h1);
		@(posedge clk);
	endtask : run

	task automatic ld(input logic [63:0] va, input logic [2:0] sz);
		logic [7:0] l;
		l = lanes(va, sz);
		run(MAU_OP_LOAD, va, sz, 0);
		chk(64'(flt), 64'h0);
		chk(last.addr, va + 64'h1000);
		chk(64'(last.lane_en), 64'(l));
		chk(64'(rsp_l), 64'(l));
		chk(rsp_d, RDAT & bm(l));
	endtask : ld

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_sizes;
		for (int s = 0; s < 8; s++) begin
			slow <= s[0];
			ld(64'h0010_0A00 | 64'(7 - s), 3'(s));
		end
	endtask : t_sizes

	task automatic t_endian;
		for (int c = 0; c < 3; c++) begin
			m64 <= (c == 0);
			be  <= (c != 2);
			@(posedge clk);
			ld(64'h0010_0A02, 3'h1);
			ld(64'h0010_0A03, MAU_SZ_BYTE);
			ld(64'h0010_0A00, MAU_SZ_WORD);
		end
	endtask : t_endian

	task automatic t_cached;
		m64 <= 1'b1;
		be  <= 1'b0;
		rq.fetch_or_data_sel <= 1'b1;
		@(posedge clk);
		run(MAU_OP_LOAD, 64'h0A45, 3'h1, 0);
		chk(last.addr, 64'h1A45 & MAU_FILL_MASK);
		chk(64'(last.fill), 64'h1);
		chk(64'(last.lane_en), 64'hFF);
		chk(64'(last.fetch_or_data_sel), 64'h1);
		chk(64'(rsp_l), 64'(lanes(64'h0A45, 3'h1)));
		chk(rsp_d, RDAT);
		rq.fetch_or_data_sel <= 1'b0;
		run(MAU_OP_PREF, 64'h0A45, 3'h0, 0);
		chk(64'(last.fill), 64'h1);
		chk(64'(rsp_l), 64'h0);
		run(MAU_OP_PREF, 64'h0010_0A45, 3'h0, 0);
		chk(64'(last.fill), 64'h0);
		chk(64'(last.lane_en), 64'h20);
		chk(64'(rsp_l), 64'h0);
		chk(rsp_d, 64'h0);
	endtask : t_cached

	task automatic t_store;
		logic [7:0]  l;
		logic [63:0] va;
		logic [2:0]  sz;
		for (int c = 0; c < 4; c++) begin
			be <= c[0];
			rq.wdata <= 64'h1122_3344_5566_7788;
			@(posedge clk);
			va = (c == 3) ? 64'h0010_0A00
				: (c == 2) ? 64'h0010_0A05 : 64'h0010_0A02;
			sz = (c == 3) ? MAU_SZ_DWORD
				: (c == 2) ? MAU_SZ_BYTE : 3'h2;
			l = lanes(va, sz);
			run(MAU_OP_STORE, va, sz, 0);
			chk(64'(last.write), 64'h1);
			chk(64'(last.lane_en), 64'(l));
			chk(last.wdata, 64'h1122_3344_5566_7788 & bm(l));
			chk(64'(rsp_l), 64'h0);
		end
	endtask : t_store

	task automatic t_fault_sync;
		logic [7:0] a;
		a = acc;
		run(MAU_OP_LOAD, 64'h0100_0000_0000, 3'h0, 0);
		chk(64'(flt), 64'h1);
		chk(64'(acc), 64'(a));
		busy <= 1'b1;
		run(MAU_OP_SYNC, 64'h0, 3'h0, 4);
		chk(64'(lat >= 6 && lat <= 8), 64'h1);
		ld(64'h0010_0A00, MAU_SZ_DWORD);
	endtask : t_fault_sync

	task automatic test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done

	initial begin
		srst = 1'b1;
		m64 = 1'b1;
		be = 1'b0;
		rq_v = 1'b0;
		slow = 1'b0;
		busy = 1'b0;
		rq = '0;
		errors = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_sizes();
		t_endian();
		t_cached();
		t_store();
		t_fault_sync();
		test_done();
	end

	initial begin
		#20us;
		errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		test_done();
	end
endmodule : testbench
